// File: logic/sebs_pkg.sv
package sebs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int WR_TIME_MS    = 5;
   // Longest time, so integer division rounds down
   localparam int WR_CYCLES     = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TIMER_W       = 21;

   ////////////////////////////////////////////////////////////////////////////
   // Control byte and address layout
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;   // Arbitrary value
   localparam int         CTRL_TYPE_MSB    = 7;
   localparam int         CTRL_TYPE_LSB    = 4;
   localparam int         CTRL_CS_MSB      = 3;
   localparam int         CTRL_CS_LSB      = 1;
   localparam int         CTRL_RW_BIT      = 0;
   localparam int         ADDR_W           = 12;
   localparam int         ADDR_HI_MSB      = 3;
   localparam int         DATA_W           = 8;
   localparam int         CS_W             = 3;
   localparam int         PAGE_W           = 5;
   localparam int         PAGE_BYTES       = 32;
   localparam logic [1:0] PROT_QUARTER     = 2'h3;
   localparam logic [3:0] BIT_LAST         = 4'h8;
   localparam logic [3:0] TX_LAST          = 4'h7;
   localparam logic [5:0] DRAIN_END        = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Commit FIFO: chip select, word address, data
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = CS_W + ADDR_W + DATA_W;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} sebs_bit_state_t;
   typedef enum logic [1:0] {PH_CTRL, PH_ADDRH, PH_ADDRL, PH_DATA} sebs_phase_t;

endpackage : sebs_pkg

// File: logic/sebs_fifo.sv
module sebs_fifo
   import sebs_pkg::*;
#(
   parameter int W     = FIFO_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic         clock,      // System clock
   input  wire logic         rst,        // Synchronous reset
   input  wire logic         in_valid,   // Write side valid
   output logic              in_ready,   // Write side has room
   input  wire logic [W-1:0] in_data,    // Write side word
   output logic              out_valid,  // Read side has a word
   input  wire logic         out_ready,  // Read side accepts
   output logic [W-1:0]      out_data    // Read side word
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wptr;
      logic [PW-1:0]           rptr;
      logic [PW:0]             count;
   } sebs_fifo_state_t;

   sebs_fifo_state_t r;
   sebs_fifo_state_t n;
   logic             push;
   logic             pop;

   // Count is one bit wider than the pointers so that DEPTH itself fits
   assign in_ready  = (r.count != (PW+1)'(DEPTH));
   assign out_valid = (r.count != '0);
   assign out_data  = r.mem[r.rptr];

   always_comb
   begin
      n    = r;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      if (push)
      begin
         n.mem[r.wptr] = in_data;
         n.wptr        = r.wptr + PW'(1);
      end
      if (pop)
      begin
         n.rptr = r.rptr + PW'(1);
      end
      if (push && !pop)
      begin
         n.count = r.count + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
         n.count = r.count - (PW+1)'(1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

endmodule : sebs_fifo

// File: logic/sebs_top.sv
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - SDA falling during SCL high is Start
// - SDA rising during SCL high is Stop
// - Data changes only while SCL low
// - One bit per SCL pulse, sampled high
// - Keep last thirty-two bytes, overwrite oldest
// - Acknowledge every byte on ninth clock
// - No acknowledge during programming cycle
// - Acknowledge holds SDA low through high
// - Master nack ends read; release SDA
// - Control byte: type, chip select, direction
// - Chip select bits must match pins
// - Direction bit one reads, zero writes
// - Two address bytes, high first, twelve used
// - Acknowledge only full match, then mode
// - Write protect blocks upper quarter writes
// - Chip select extends word address upward
// - Stop after write starts timed cycle
// - Protect sampled at Stop; blocked frees immediately
// - Writes increment only low five pointer bits; reads all twelve
// - Write cycle lasts five milliseconds, longer while the array stalls the drain
module sebs_top
   import sebs_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE     = DEV_TYPE_DEFAULT,  // Arbitrary device type code
   parameter int         WRITE_CYCLES = WR_CYCLES          // Write cycle length in clocks
)
(
   input  wire logic                    clock,              // 250 MHz system clock
   input  wire logic                    rst,                // Synchronous reset, high
   input  wire logic                    scl_in,             // Serial clock pin
   input  wire logic                    sda_in,             // Serial data pin level
   output logic                         sda_out,            // Serial data drive value
   output logic                         sda_oe_n,           // Low while pulling SDA low
   input  wire logic                    chip_select_pin_0,  // Chip address pin 0
   input  wire logic                    chip_select_pin_1,  // Chip address pin 1
   input  wire logic                    chip_select_pin_2,  // Chip address pin 2
   input  wire logic                    write_protect,      // Upper quarter protect pin
   output logic [CS_W+ADDR_W-1:0]       rd_addr,            // Extended read address
   input  wire logic [DATA_W-1:0]       rd_data,            // Array data at rd_addr
   output logic                         busy,               // Write cycle in progress
   output logic                         wr_valid,           // Committed byte available
   input  wire logic                    wr_ready,           // Array takes committed byte
   output logic [FIFO_W-1:0]            wr_word             // Chip select, address, data
);

   typedef struct packed {
      logic                               scl_s1;
      logic                               scl_s2;
      logic                               scl_q;
      logic                               sda_s1;
      logic                               sda_s2;
      logic                               sda_q;
      logic                               wp_s1;
      logic                               wp_s2;
      logic [CS_W-1:0]                    cs_s1;
      logic [CS_W-1:0]                    cs_s2;
      sebs_bit_state_t                    st;
      sebs_phase_t                        ph;
      logic [3:0]                         cnt;
      logic [DATA_W-1:0]                  sh;
      logic                               rd_mode;
      logic                               nack;
      logic [ADDR_W-1:0]                  ptr;
      logic [PAGE_BYTES-1:0]              mask;
      logic [PAGE_BYTES-1:0][DATA_W-1:0]  pbuf;
      logic                               drain;
      logic [5:0]                         didx;
      logic                               busy;
      logic [TIMER_W-1:0]                 timer;
      logic                               sda_oe_n;
      logic [CS_W+ADDR_W-1:0]             rd_addr;
   } sebs_state_t;
   sebs_state_t       r;
   sebs_state_t       n;
   logic              rise_evt;
   logic              fall_evt;
   logic              start_evt;
   logic              stop_evt;
   logic              fifo_in_valid;
   logic              fifo_in_ready;
   logic [FIFO_W-1:0] fifo_in_data;
   logic              ctrl_match;
   logic              wp_block;

   ////////////////////////////////////////////////////////////////////////////
   // Edges and bus conditions from the second and third sample stages
   assign rise_evt  = r.scl_s2 && !r.scl_q;
   assign fall_evt  = !r.scl_s2 && r.scl_q;
   assign start_evt = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
   assign stop_evt  = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
   // Busy check covers the control byte too, which gives acknowledge polling
   assign ctrl_match = (r.sh[CTRL_TYPE_MSB:CTRL_TYPE_LSB] == DEV_TYPE)
                    && (r.sh[CTRL_CS_MSB:CTRL_CS_LSB] == r.cs_s2)
                    && !r.busy;
   // Protect level as sampled at this Stop; later toggles have no effect
   assign wp_block = r.wp_s2 && (r.ptr[ADDR_W-1:ADDR_W-2] == PROT_QUARTER);
   assign sda_out  = 1'b0;
   assign sda_oe_n = r.sda_oe_n;
   assign busy     = r.busy;
   assign rd_addr  = r.rd_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      n             = r;
      n.scl_s1      = scl_in;
      n.scl_s2      = r.scl_s1;
      n.scl_q       = r.scl_s2;
      n.sda_s1      = sda_in;
      n.sda_s2      = r.sda_s1;
      n.sda_q       = r.sda_s2;
      n.wp_s1       = write_protect;
      n.wp_s2       = r.wp_s1;
      n.cs_s1       = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      n.cs_s2       = r.cs_s1;
      fifo_in_valid = 1'b0;
      // Chip select on top makes the address contiguous across devices
      fifo_in_data  = {r.cs_s2, r.ptr[ADDR_W-1:PAGE_W], r.didx[PAGE_W-1:0],
                       r.pbuf[r.didx[PAGE_W-1:0]]};
      if (start_evt)
      begin
         n.st       = ST_RX;
         n.ph       = PH_CTRL;
         n.cnt      = 4'h0;
         n.sda_oe_n = 1'b1;
      end
      else if (stop_evt)
      begin
         n.st       = ST_IDLE;
         n.sda_oe_n = 1'b1;
         if (r.ph == PH_DATA && !r.rd_mode && (r.mask != '0))
         begin
            if (wp_block)
            begin
               n.mask = '0;
            end
            else
            begin
               n.drain = 1'b1;
               n.didx  = 6'h00;
               n.busy  = 1'b1;
               n.timer = TIMER_W'(WRITE_CYCLES);
            end
         end
      end
      else
      begin
         case (r.st)
            ST_RX:
            begin
               if (rise_evt)
               begin
                  n.sh  = {r.sh[DATA_W-2:0], r.sda_s2};
                  n.cnt = r.cnt + 4'h1;
               end
               else if (fall_evt && r.cnt == BIT_LAST)
               begin
                  n.cnt      = 4'h0;
                  n.st       = ST_ACK;
                  n.sda_oe_n = 1'b0;
                  case (r.ph)
                     PH_CTRL:
                     begin
                        n.rd_mode = r.sh[CTRL_RW_BIT];
                        n.ph      = PH_ADDRH;
                        if (!ctrl_match)
                        begin
                           n.st       = ST_IDLE;
                           n.sda_oe_n = 1'b1;
                        end
                     end
                     PH_ADDRH:
                     begin
                        // Upper four bits of the high byte are ignored
                        n.ptr[ADDR_W-1:DATA_W] = r.sh[ADDR_HI_MSB:0];
                        n.ph                   = PH_ADDRL;
                     end
                     PH_ADDRL:
                     begin
                        n.ptr[DATA_W-1:0] = r.sh;
                        n.mask            = '0;
                        n.ph              = PH_DATA;
                     end
                     default:
                     begin
                        // Slot follows the pointer, so byte 33 lands on byte 1
                        n.pbuf[r.ptr[PAGE_W-1:0]] = r.sh;
                        n.mask[r.ptr[PAGE_W-1:0]] = 1'b1;
                        n.ptr[PAGE_W-1:0] = r.ptr[PAGE_W-1:0] + PAGE_W'(1);
                     end
                  endcase
               end
            end
            ST_ACK:
            begin
               if (fall_evt)
               begin
                  n.sda_oe_n = 1'b1;
                  if (r.rd_mode)
                  begin
                     n.sh       = rd_data;
                     n.sda_oe_n = rd_data[DATA_W-1];
                     n.ptr      = r.ptr + ADDR_W'(1);
                     n.cnt      = 4'h0;
                     n.st       = ST_TX;
                  end
                  else
                  begin
                     n.st = ST_RX;
                  end
               end
            end
            ST_TX:
            begin
               if (fall_evt)
               begin
                  n.cnt = r.cnt + 4'h1;
                  n.sh  = {r.sh[DATA_W-2:0], 1'b0};
                  if (r.cnt == TX_LAST)
                  begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_TXACK;
                  end
                  else
                  begin
                     n.sda_oe_n = r.sh[DATA_W-2];
                  end
               end
            end
            ST_TXACK:
            begin
               if (rise_evt)
               begin
                  n.nack = r.sda_s2;
               end
               else if (fall_evt)
               begin
                  if (r.nack)
                  begin
                     n.st       = ST_IDLE;
                     n.sda_oe_n = 1'b1;
                  end
                  else
                  begin
                     n.sh       = rd_data;
                     n.sda_oe_n = rd_data[DATA_W-1];
                     n.ptr      = r.ptr + ADDR_W'(1);
                     n.cnt      = 4'h0;
                     n.st       = ST_TX;
                  end
               end
            end
            default:
            begin
               n.st = ST_IDLE;
            end
         endcase
      end
      // Commit drains the page buffer; array back-pressure stretches busy
      if (r.drain)
      begin
         if (r.didx == DRAIN_END)
         begin
            n.drain = 1'b0;
            n.mask  = '0;
         end
         else if (!r.mask[r.didx[PAGE_W-1:0]])
         begin
            n.didx = r.didx + 6'h01;
         end
         else
         begin
            fifo_in_valid = 1'b1;
            if (fifo_in_ready)
            begin
               n.didx = r.didx + 6'h01;
            end
         end
      end
      if (r.timer != '0)
      begin
         n.timer = r.timer - TIMER_W'(1);
      end
      else if (!r.drain && !n.drain)
      begin
         n.busy = 1'b0;
      end
      n.rd_addr = {r.cs_s2, n.ptr};
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r          <= '0;
         r.sda_oe_n <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Commit buffer toward the array
   sebs_fifo #(
      .W     (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_START_RX: assert property (start_evt |=> (r.st == ST_RX) && (r.cnt == 4'h0) && (r.ph == PH_CTRL))
      else $error("Start not taken");
   AST_STOP_IDLE: assert property (stop_evt |=> (r.st == ST_IDLE) && r.sda_oe_n)
      else $error("Stop not taken");
   AST_DRIVE_SCL_LOW: assert property ($changed(r.sda_oe_n) && !$past(start_evt) && !$past(stop_evt)
                                       |-> !$past(r.scl_s2))
      else $error("SDA drive changed while SCL high");
   AST_BUSY_NO_ACK: assert property ((fall_evt && r.st == ST_RX && r.cnt == BIT_LAST && r.ph == PH_CTRL
                                      && r.busy && !start_evt && !stop_evt) |=> (r.st == ST_IDLE) && r.sda_oe_n)
      else $error("Acknowledge given while busy");
   AST_ACK_LOW: assert property ((r.st == ST_ACK) && r.scl_s2 |-> !r.sda_oe_n)
      else $error("Acknowledge not held low");
   AST_CS_MISMATCH: assert property ((fall_evt && r.st == ST_RX && r.cnt == BIT_LAST && r.ph == PH_CTRL
                                      && r.sh[CTRL_CS_MSB:CTRL_CS_LSB] != r.cs_s2 && !start_evt && !stop_evt)
                                     |=> r.st == ST_IDLE)
      else $error("Responded to foreign chip select");
   AST_NACK_RELEASE: assert property ((r.st == ST_TXACK && r.nack && fall_evt && !start_evt && !stop_evt)
                                      |=> (r.st == ST_IDLE) ##1 r.sda_oe_n [*3])
      else $error("SDA not released after nack");
   AST_WP_BLOCK: assert property ((stop_evt && r.ph == PH_DATA && !r.rd_mode && wp_block && !r.busy)
                                  |=> !r.busy && !r.drain && (r.mask == '0))
      else $error("Protected write not blocked");
   AST_PAGE_WRAP: assert property ((fall_evt && r.st == ST_RX && r.cnt == BIT_LAST && r.ph == PH_DATA
                                    && !start_evt && !stop_evt)
                                   |=> $stable(r.ptr[ADDR_W-1:PAGE_W])
                                       && (r.ptr[PAGE_W-1:0] == $past(r.ptr[PAGE_W-1:0]) + PAGE_W'(1)))
      else $error("Page pointer increment wrong");
   AST_TIMER_LOAD: assert property ($rose(r.busy) |-> (r.timer == TIMER_W'(WRITE_CYCLES)) && $past(stop_evt))
      else $error("Write cycle not started by Stop");
   AST_TIMER_BOUND: assert property (r.timer <= TIMER_W'(WRITE_CYCLES))
      else $error("Write timer above limit");

   COV_CTRL_ACK: cover property ((r.st == ST_ACK) && (r.ph == PH_ADDRH) && !r.rd_mode);
   COV_READ_BYTE: cover property ((r.st == ST_TXACK) && fall_evt && r.nack);
   COV_COMMIT: cover property ($rose(r.busy));
   COV_WRAP: cover property (r.st == ST_ACK && r.ph == PH_DATA && r.mask == '1);

endmodule : sebs_top

// File: tb/sebs_master.sv
module sebs_master
(
   input  wire logic clock,   // System clock
   input  wire logic sda,     // Resolved data wire
   output logic      scl,     // Serial clock
   output logic      sda_low  // High pulls data low
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 10;  // 80 ns link period

   initial
   begin
      scl = 1'h1;
      sda_low = 1'h0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   task automatic sample(output logic v);
      @(negedge clock);
      v = sda;
   endtask : sample

   ////////////////////////////////////////////////////////////////////////////
   // Data moves mid-low; high phase sampled near both ends
   task automatic put_bit(input logic b, output logic seen);
      logic s;
      logic e;
      tick(HALF / 2);
      sda_low <= ~b;
      tick(HALF / 2);
      scl <= 1'h1;
      sample(s);
      tick(HALF - 1);
      sample(e);
      tick(1);
      scl <= 1'h0;
      seen = s | e;
   endtask : put_bit

   // One spare clock first so the data edge never meets the clock fall
   task automatic start();
      tick(1);
      sda_low <= 1'h0;
      tick(HALF / 2);
      scl <= 1'h1;
      tick(HALF);
      sda_low <= 1'h1;
      tick(HALF);
      scl <= 1'h0;
   endtask : start

   // Clock then stands high until the next frame
   task automatic stop();
      tick(1);
      sda_low <= 1'h1;
      tick(HALF / 2);
      scl <= 1'h1;
      tick(HALF);
      sda_low <= 1'h0;
      tick(HALF);
   endtask : stop

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(b[i], s);
      put_bit(1'h1, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(1'h1, b[i]);
      put_bit(~ack, s);
   endtask : rd_byte

endmodule : sebs_master

// File: tb/tb_sebs_top.sv
module tb_sebs_top
   import sebs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clock = 1'h0;
   logic                 rst = 1'h1;
   logic                 scl;
   logic                 sda;
   logic                 sda_low;
   logic                 sda_oe_n;
   logic                 sda_out;
   logic [2:0]           pins = 3'h0;
   logic                 write_protect = 1'h0;
   logic [14:0]          rd_addr;
   logic [7:0]           rd_data;
   logic                 busy;
   logic                 wr_valid;
   logic                 wr_ready = 1'h0;
   logic [FIFO_W-1:0]    wr_word;
   logic [FIFO_W-1:0]    got[$];
   logic [7:0]           exp_data[32];
   int                   seed = 97;
   int                   num_errors = 0;
   int                   samples_checked = 0;

   function automatic logic [7:0] array_byte(input logic [14:0] a);
      return a[7:0] ^ {1'h0, a[14:8]};
   endfunction : array_byte

   always #2 clock = ~clock;
   // Pull-up: the wire is high unless someone pulls it
   assign sda = ~(sda_low | ~sda_oe_n);
   assign rd_data = array_byte(rd_addr);

   // Random stalls on the commit side keep the drain honest
   always @(posedge clock)
   begin
      wr_ready <= ($random(seed) & 3) != 0;
      if (wr_valid && wr_ready)
         got.push_back(wr_word);
   end

   sebs_master i_sebs_master (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

   sebs_top #(.WRITE_CYCLES(200)) i_sebs_top (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_pin_0(pins[0]), .chip_select_pin_1(pins[1]),
      .chip_select_pin_2(pins[2]), .write_protect(write_protect), .rd_addr(rd_addr), .rd_data(rd_data),
      .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wsend(input logic [7:0] b, input logic exp_ack);
      logic a;
      i_sebs_master.wr_byte(b, a);
      check("acknowledge", a, exp_ack);
   endtask : wsend

   task automatic settle(input int n);
      int t = 0;
      while ((busy !== 1'h0 || got.size() != n) && t < 3000)
      begin
         @(posedge clock);
         t++;
      end
      if (t == 3000)
      begin
         num_errors++;
         wrap_up();
      end
   endtask : settle

   initial
   begin
      repeat (100000) @(posedge clock);
      num_errors++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [11:0] addr;
      logic [7:0]  d;
      logic [7:0]  ctrl_w;
      repeat (10) @(posedge clock);
      pins <= 3'($random(seed));
      rst <= 1'h0;
      repeat (10) @(posedge clock);
      ctrl_w = {DEV_TYPE_DEFAULT, pins, 1'h0};
      // Every select code, then a wrong type code
      for (int i = 0; i < 9; i++)
      begin
         i_sebs_master.start();
         d = (i < 8) ? {DEV_TYPE_DEFAULT, 3'(i), 1'h0} : ctrl_w ^ 8'h80;
         wsend(d, i < 8 && 3'(i) == pins);
         i_sebs_master.stop();
         settle(0);
      end
      // Page write two bytes past the buffer from a random slot
      addr = {2'h1, 10'($random(seed))};
      i_sebs_master.start();
      wsend(ctrl_w, 1'h1);
      wsend({4'($random(seed)), addr[11:8]}, 1'h1);
      wsend(addr[7:0], 1'h1);
      for (int k = 0; k < 34; k++)
      begin
         d = 8'($random(seed));
         exp_data[5'(addr[4:0] + k)] = d;
         wsend(d, 1'h1);
      end
      i_sebs_master.stop();
      check("busy after stop", busy, 1'h1);
      i_sebs_master.start();
      wsend(ctrl_w, 1'h0);
      i_sebs_master.stop();
      settle(32);
      for (int j = 0; j < 32; j++)
         check("commit word", got[j], {pins, addr[11:5], 5'(j), exp_data[j]});
      got.delete();
      // Protected quarter
      write_protect <= 1'h1;
      addr = {2'h3, 10'($random(seed))};
      i_sebs_master.start();
      wsend(ctrl_w, 1'h1);
      wsend({4'h0, addr[11:8]}, 1'h1);
      wsend(addr[7:0], 1'h1);
      wsend(8'($random(seed)), 1'h1);
      i_sebs_master.stop();
      check("busy when protected", busy, 1'h0);
      i_sebs_master.start();
      wsend(ctrl_w, 1'h1);
      i_sebs_master.stop();
      // Random read across a repeated start, protect still high
      addr = 12'($random(seed));
      i_sebs_master.start();
      wsend(ctrl_w, 1'h1);
      wsend({4'h0, addr[11:8]}, 1'h1);
      wsend(addr[7:0], 1'h1);
      i_sebs_master.start();
      wsend(ctrl_w | 8'h01, 1'h1);
      i_sebs_master.rd_byte(d, 1'h1);
      check("read byte", d, array_byte({pins, addr}));
      i_sebs_master.rd_byte(d, 1'h0);
      check("next read byte", d, array_byte({pins, addr + 12'h001}));
      i_sebs_master.tick(4);
      @(negedge clock);
      check("released after nack", sda_oe_n, 1'h1);
      // A missed nack would have fetched a third byte and moved the pointer on
      check("pointer after read", rd_addr, {pins, addr + 12'h002});
      check("drive value", sda_out, 1'h0);
      i_sebs_master.stop();
      check("protected commits", got.size(), 0);
      wrap_up();
   end

endmodule : tb_sebs_top
